// >>> src/gpc_pin_config.sv
// Pin function configuration block with Avalon-MM register access
// Summary of operation
// - Led select bits 30:28 turn pins 0..2 into LED outputs.
// - Polarity bits 26:24 choose which pin level sets its status bit.
// - Pin interrupt reaches host only when its mask enable is set.
// - Select field 22:20 routes the two EEPROM pins per its table.
// - Buffer type bits 18:16 give push-pull when set, open-drain when clear.
// - Direction bits 10:8 make a pin output when one, input when zero.
// - Bits 4:3 drive general outputs 3 and 4, read back as written.
// - Bits 2:0 drive output pins; reads return live pin levels.
//
// Chosen here: register access over Avalon-MM.
module gpc_pin_config
   import gpc_pkg::*;
(
   input  wire logic        core_clk_in,          // System clock
   input  wire logic        nrst_in,              // Sync reset, low
   input  wire logic [7:0]  avs_address_in,       // Byte address
   input  wire logic        avs_read_in,          // Read request
   input  wire logic        avs_write_in,         // Write request
   input  wire logic [31:0] avs_writedata_in,     // Write data
   input  wire logic [3:0]  avs_byteenable_in,    // Byte lanes
   output logic      [31:0] avs_readdata_out,     // Read data
   output logic             avs_waitrequest_out,  // Stall
   output logic             irq_out,              // Level interrupt
   input  wire logic [2:0]  gpio_in,              // Pin levels
   output logic      [2:0]  gpio_out,             // Pin drive levels
   output logic      [2:0]  gpio_oe_n_out,        // Pin enables, low
   input  wire logic [2:0]  led_link_in,          // LED sources
   input  wire logic        ee_data_out_in,       // EEPROM ctl data
   input  wire logic        ee_data_oe_in,        // EEPROM ctl enable
   input  wire logic        ee_clock_in,          // EEPROM ctl clock
   output logic             ee_data_in_out,       // Data pin to ctl
   input  wire logic        tx_en_in,             // MII transmit enable
   input  wire logic        rx_dv_in,             // MII receive valid
   input  wire logic        tx_clk_in,            // MII transmit clock
   input  wire logic        rx_clk_in,            // MII receive clock
   input  wire logic        eeprom_data_pin_in,   // Data pin level
   output logic             eeprom_data_pin_out,  // Data pin drive
   output logic             eeprom_data_pin_oe_n_out, // Data enable, low
   output logic             eeprom_clock_pin_out  // Clock pin drive
);

   // Stored registers
   gpc_cfg_t   cfg_q;
   gpc_cfg_t   cfg_d;
   logic [2:0] sts_q;
   logic [2:0] sts_d;
   logic [2:0] mask_q;
   logic [2:0] mask_d;

   // Bus handshake and read data
   logic        ack_q;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;

   // Pin and routing results
   gpc_drive_t  drive [3];
   logic [2:0]  level;
   logic [2:0]  hit;
   logic        ee_dout_q;
   logic        ee_doe_n_q;
   logic        ee_clk_q;
   logic        ee_dout_d;
   logic        ee_doe_n_d;
   logic        ee_clk_d;

   // Bus decode wires
   logic        req;
   logic        take;
   logic        wr_take;
   logic        sel_cfg;
   logic        sel_sts;
   logic        sel_mask;
   logic        hit_map;
   logic [31:0] be_mask;
   logic [31:0] cfg_word;
   logic [31:0] cfg_rd;
   logic [31:0] cfg_wr;
   logic [31:0] sts_rd;
   logic [31:0] mask_rd;
   logic [2:0]  w1c;
   logic [2:0]  mask_wr;

   // Field views of the configuration
   logic [2:0]  led_sel;
   logic [2:0]  pol;
   gpc_ee_sel_t ee_sel;
   logic [2:0]  buf_pp;
   logic [2:0]  dir;
   logic [1:0]  gpo;
   logic [2:0]  pdata;
   logic        general_output_3;
   logic        general_output_4;

   //------------------------------------------------------------------
   // Avalon-MM slave: one wait cycle, answer on the second edge
   //------------------------------------------------------------------

   // A request is answered one cycle after it rises
   assign req     = avs_read_in | avs_write_in;
   assign take    = req & ack_q;
   assign wr_take = avs_write_in & ack_q;
   assign avs_waitrequest_out = req & ~ack_q;

   // Address decode, low two address bits ignored
   assign sel_cfg  = (avs_address_in[7:2] == GPC_CFG_OFFSET[7:2]);
   assign sel_sts  = (avs_address_in[7:2] == GPC_STS_OFFSET[7:2]);
   assign sel_mask = (avs_address_in[7:2] == GPC_MASK_OFFSET[7:2]);
   assign hit_map  = sel_cfg | sel_sts | sel_mask;

   // Byte enables widened to a bit mask
   assign be_mask = {{8{avs_byteenable_in[3]}},
                     {8{avs_byteenable_in[2]}},
                     {8{avs_byteenable_in[1]}},
                     {8{avs_byteenable_in[0]}}};

   // Handshake flop; drops after each answer so requests can chain
   always_ff @(posedge core_clk_in) begin
      if (!nrst_in) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= req & ~ack_q;
      end
   end

   //------------------------------------------------------------------
   // Configuration register
   //------------------------------------------------------------------

   // Field views
   assign led_sel = cfg_q.led_select;
   assign pol     = cfg_q.pin_irq_polarity;
   assign ee_sel  = cfg_q.eeprom_pin_select;
   assign buf_pp  = cfg_q.pin_buffer_type;
   assign dir     = cfg_q.pin_direction;
   assign gpo     = cfg_q.general_output_data;
   assign pdata   = cfg_q.pin_data;
   assign general_output_3    = gpo[0];
   assign general_output_4    = gpo[1];

   // Stored word; reserved bits only ever hold zero
   assign cfg_word = GPC_CFG_WR_MASK & cfg_q;

   // Readback swaps the stored pin data for live pin levels
   assign cfg_rd = {cfg_word[31:3], gpio_in};

   // Masked write keeps unselected lanes and reserved bits out
   assign cfg_wr = (cfg_word & ~(be_mask & GPC_CFG_WR_MASK))
                 | (avs_writedata_in & be_mask & GPC_CFG_WR_MASK);

   assign cfg_d = (wr_take && sel_cfg) ? gpc_cfg_t'(cfg_wr) : cfg_q;

   // Reserved select codes are stored as written; routing idles for them
   always_ff @(posedge core_clk_in) begin
      if (!nrst_in) begin
         cfg_q <= gpc_cfg_t'(GPC_CFG_RESET);
      end else begin
         cfg_q <= cfg_d;
      end
   end

   //------------------------------------------------------------------
   // Interrupt status and mask
   //------------------------------------------------------------------

   // Write-one-to-clear uses the lowest byte lane only
   assign w1c     = (wr_take && sel_sts && avs_byteenable_in[0])
                    ? avs_writedata_in[2:0] : 3'h0;
   assign mask_wr = avs_writedata_in[2:0];

   // A level still present re-sets the bit; set beats clear
   assign sts_d  = (sts_q & ~w1c) | hit;
   assign mask_d = (wr_take && sel_mask && avs_byteenable_in[0])
                   ? mask_wr : mask_q;

   always_ff @(posedge core_clk_in) begin
      if (!nrst_in) begin
         sts_q  <= GPC_IRQ_RESET;
         mask_q <= GPC_IRQ_RESET;
      end else begin
         sts_q  <= sts_d;
         mask_q <= mask_d;
      end
   end

   // Polarity alone never interrupts; the enable must also be set
   assign irq_out = |(sts_q & mask_q);

   assign sts_rd  = {29'h0, sts_q};
   assign mask_rd = {29'h0, mask_q};

   //------------------------------------------------------------------
   // Read data
   //------------------------------------------------------------------

   // Unmapped addresses read zero and take no write
   assign rdata_d = sel_cfg  ? cfg_rd  :
                    sel_sts  ? sts_rd  :
                    sel_mask ? mask_rd : GPC_RD_ZERO;

   // Captured on the stall cycle so it stands at the answer edge
   always_ff @(posedge core_clk_in) begin
      if (!nrst_in) begin
         rdata_q <= GPC_RD_ZERO;
      end else if (avs_read_in && !ack_q) begin
         rdata_q <= hit_map ? rdata_d : GPC_RD_ZERO;
      end
   end

   assign avs_readdata_out = rdata_q;

   //------------------------------------------------------------------
   // Shared GPIO/LED pins
   //------------------------------------------------------------------

   // One cell and one level qualifier per pin
   for (genvar i = 0; i < 3; i++) begin : g_pin
      gpc_pin_cell u_cell (
         .core_clk_in  (core_clk_in),
         .nrst_in      (nrst_in),
         .led_sel_in   (led_sel[i]),
         .dir_in       (dir[i]),
         .push_pull_in (buf_pp[i]),
         .data_in      (pdata[i]),
         .pol_in       (pol[i]),
         .led_in       (led_link_in[i]),
         .pin_in       (gpio_in[i]),
         .drive_out    (drive[i]),
         .level_out    (level[i])
      );

      // Only levels held the qualifying time are counted
      gpc_level_filter u_filt (
         .core_clk_in (core_clk_in),
         .nrst_in     (nrst_in),
         .level_in    (level[i]),
         .hit_out     (hit[i])
      );

      assign gpio_out[i]      = drive[i].out;
      assign gpio_oe_n_out[i] = drive[i].oe_n;
   end

   //------------------------------------------------------------------
   // EEPROM pin routing
   //------------------------------------------------------------------

   // Data pin always reports its level to the EEPROM controller
   assign ee_data_in_out = eeprom_data_pin_in;

   // Reserved codes release the data pin and hold the clock low
   always_comb begin
      ee_dout_d  = 1'b0;
      ee_doe_n_d = 1'b1;
      ee_clk_d   = 1'b0;
      case (ee_sel)
         GPC_EE_EEPROM: begin
            ee_dout_d  = ee_data_out_in;
            ee_doe_n_d = ~ee_data_oe_in;
            ee_clk_d   = ee_clock_in;
         end
         GPC_EE_GPO: begin
            ee_dout_d  = general_output_3;
            ee_doe_n_d = 1'b0;
            ee_clk_d   = general_output_4;
         end
         GPC_EE_GENERAL_OUTPUT_3_DV: begin
            ee_dout_d  = general_output_3;
            ee_doe_n_d = 1'b0;
            ee_clk_d   = rx_dv_in;
         end
         GPC_EE_TXEN_G4: begin
            ee_dout_d  = tx_en_in;
            ee_doe_n_d = 1'b0;
            ee_clk_d   = general_output_4;
         end
         GPC_EE_TXEN_DV: begin
            ee_dout_d  = tx_en_in;
            ee_doe_n_d = 1'b0;
            ee_clk_d   = rx_dv_in;
         end
         GPC_EE_CLKS: begin
            ee_dout_d  = tx_clk_in;
            ee_doe_n_d = 1'b0;
            ee_clk_d   = rx_clk_in;
         end
         default: begin
            ee_dout_d  = 1'b0;
            ee_doe_n_d = 1'b1;
            ee_clk_d   = 1'b0;
         end
      endcase
   end

   // Registered outputs; monitored clocks are resampled, so they
   // only look right when well below half the system clock
   always_ff @(posedge core_clk_in) begin
      if (!nrst_in) begin
         ee_dout_q  <= 1'b0;
         ee_doe_n_q <= 1'b1;
         ee_clk_q   <= 1'b0;
      end else begin
         ee_dout_q  <= ee_dout_d;
         ee_doe_n_q <= ee_doe_n_d;
         ee_clk_q   <= ee_clk_d;
      end
   end

   assign eeprom_data_pin_out      = ee_dout_q;
   assign eeprom_data_pin_oe_n_out = ee_doe_n_q;
   assign eeprom_clock_pin_out     = ee_clk_q;

endmodule

// >>> src/gpc_pkg.sv
// Package for the pin function configuration block: map, fields, types
package gpc_pkg;

   // Register byte offsets
   localparam logic [7:0] GPC_CFG_OFFSET  = 8'h88;
   localparam logic [7:0] GPC_STS_OFFSET  = 8'h00;
   localparam logic [7:0] GPC_MASK_OFFSET = 8'h04;

   // Field positions in the configuration word
   localparam int GPC_LED_SEL_LSB = 28;
   localparam int GPC_POL_LSB     = 24;
   localparam int GPC_EE_SEL_LSB  = 20;
   localparam int GPC_BUF_LSB     = 16;
   localparam int GPC_DIR_LSB     = 8;
   localparam int GPC_GPO_LSB     = 3;
   localparam int GPC_DATA_LSB    = 0;

   // Writable bits of the configuration word; the rest are reserved
   localparam logic [31:0] GPC_CFG_WR_MASK = 32'h7777_071F;

   // Values after reset
   localparam logic [31:0] GPC_CFG_RESET = 32'h0000_0000;
   localparam logic [2:0]  GPC_IRQ_RESET = 3'h0;
   localparam logic [31:0] GPC_RD_ZERO   = 32'h0000_0000;

   // Interrupt level qualification time
   localparam int GPC_CLK_PERIOD_NS = 10;
   localparam int GPC_IRQ_LEVEL_NS  = 40;
   localparam int GPC_IRQ_CYC_RAW   = GPC_IRQ_LEVEL_NS / GPC_CLK_PERIOD_NS;
   localparam int GPC_IRQ_CYCLES    = (GPC_IRQ_CYC_RAW < 1) ? 1 : GPC_IRQ_CYC_RAW;

   // Pin routing choices for the two EEPROM pins
   typedef enum logic [2:0] {
      GPC_EE_EEPROM  = 3'h0,
      GPC_EE_GPO     = 3'h1,
      GPC_EE_RSV2    = 3'h2,
      GPC_EE_GENERAL_OUTPUT_3_DV = 3'h3,
      GPC_EE_RSV4    = 3'h4,
      GPC_EE_TXEN_G4 = 3'h5,
      GPC_EE_TXEN_DV = 3'h6,
      GPC_EE_CLKS    = 3'h7
   } gpc_ee_sel_t;

   // Configuration word as fields
   typedef struct packed {
      logic        rsv31;
      logic [2:0]  led_select;
      logic        rsv27;
      logic [2:0]  pin_irq_polarity;
      logic        rsv23;
      gpc_ee_sel_t eeprom_pin_select;
      logic        rsv19;
      logic [2:0]  pin_buffer_type;
      logic [4:0]  rsv15;
      logic [2:0]  pin_direction;
      logic [2:0]  rsv7;
      logic [1:0]  general_output_data;
      logic [2:0]  pin_data;
   } gpc_cfg_t;

   // One driven pin: level and active-low enable
   typedef struct packed {
      logic out;
      logic oe_n;
   } gpc_drive_t;

endpackage

// >>> src/gpc_pin_cell.sv
// One shared GPIO/LED pin: driver selection and interrupt level
module gpc_pin_cell
   import gpc_pkg::*;
(
   input  wire logic       core_clk_in,  // System clock
   input  wire logic       nrst_in,      // Sync reset, low
   input  wire logic       led_sel_in,   // Pin taken as LED
   input  wire logic       dir_in,       // 1 output, 0 input
   input  wire logic       push_pull_in, // 1 push-pull, 0 open-drain
   input  wire logic       data_in,      // Written pin data
   input  wire logic       pol_in,       // Interrupt level
   input  wire logic       led_in,       // LED source level
   input  wire logic       pin_in,       // Pin level seen
   output gpc_drive_t      drive_out,    // Pin drive, registered
   output logic            level_out     // Active interrupt level
);

   logic drv_en;
   logic drv_val;
   gpc_drive_t drive_q;
   gpc_drive_t drive_d;

   // LED function overrides direction and buffer type
   assign drv_val = led_sel_in ? led_in : data_in;
   // Open-drain only pulls low; high is released
   assign drv_en  = led_sel_in | (dir_in & (push_pull_in | ~data_in));
   assign drive_d = '{out: drv_val, oe_n: ~drv_en};

   // Polarity picks which level counts; LED pins raise none
   assign level_out = ~led_sel_in & ~(pin_in ^ pol_in);

   // Registered so the pad sees no decode glitches
   always_ff @(posedge core_clk_in) begin
      if (!nrst_in) begin
         drive_q <= '{out: 1'b0, oe_n: 1'b1};
      end else begin
         drive_q <= drive_d;
      end
   end

   assign drive_out = drive_q;

endmodule

// >>> src/gpc_level_filter.sv
// Level qualifier: flags a level held for the required cycles
module gpc_level_filter
   import gpc_pkg::*;
(
   input  wire logic core_clk_in,  // System clock
   input  wire logic nrst_in,      // Sync reset, low
   input  wire logic level_in,     // Raw active level
   output logic      hit_out       // Level qualified
);

   logic [3:0] cnt_q;
   logic [3:0] cnt_d;
   logic       full;

   // Short glitches restart the count and are not seen
   assign full  = (cnt_q >= 4'(GPC_IRQ_CYCLES));
   assign cnt_d = !level_in ? 4'h0 : (full ? cnt_q : cnt_q + 4'h1);

   always_ff @(posedge core_clk_in) begin
      if (!nrst_in) begin
         cnt_q <= 4'h0;
      end else begin
         cnt_q <= cnt_d;
      end
   end

   assign hit_out = full;

endmodule

// >>> test/gpc_pin_config_assertions.sv
// Checker for the pin function configuration block, bound to its ports
module gpc_pin_config_chk
   import gpc_pkg::*;
(
   input wire logic        core_clk_in,              // Clock
   input wire logic        nrst_in,                  // Reset, low
   input wire logic [7:0]  avs_address_in,           // Address
   input wire logic        avs_read_in,              // Read
   input wire logic        avs_write_in,             // Write
   input wire logic [31:0] avs_writedata_in,         // Write data
   input wire logic [3:0]  avs_byteenable_in,        // Lanes
   input wire logic [31:0] avs_readdata_out,         // Read data
   input wire logic        avs_waitrequest_out,      // Stall
   input wire logic        irq_out,                  // Interrupt
   input wire logic [2:0]  gpio_out,                 // Pin drive
   input wire logic [2:0]  gpio_oe_n_out,            // Pin enable
   input wire logic [2:0]  led_link_in,              // LED sources
   input wire logic        ee_clock_in,              // Ctl clock
   input wire logic        tx_en_in,                 // Monitor
   input wire logic        rx_dv_in,                 // Monitor
   input wire logic        tx_clk_in,                // Monitor
   input wire logic        rx_clk_in,                // Monitor
   input wire logic        eeprom_data_pin_out,      // Data pin
   input wire logic        eeprom_data_pin_oe_n_out, // Data enable
   input wire logic        eeprom_clock_pin_out      // Clock pin
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] cfg_q;
   logic [2:0]  mask_q;
   gpc_cfg_t    cv;

   // Shadow of the host writes, so pin checks need no view inside
   always_ff @(posedge core_clk_in) begin
      if (!nrst_in) begin
         cfg_q  <= GPC_CFG_RESET;
         mask_q <= GPC_IRQ_RESET;
      end else if (avs_write_in && !avs_waitrequest_out) begin
         for (int b = 0; b < 4; b++)
            if (avs_byteenable_in[b] && avs_address_in[7:2] == GPC_CFG_OFFSET[7:2])
               cfg_q[8*b +: 8] <= avs_writedata_in[8*b +: 8] & GPC_CFG_WR_MASK[8*b +: 8];
         if (avs_byteenable_in[0] && avs_address_in[7:2] == GPC_MASK_OFFSET[7:2])
            mask_q <= avs_writedata_in[2:0];
      end
   end

   // Pin classes and expected EEPROM pin levels from the shadow
   assign cv = gpc_cfg_t'(cfg_q);
   wire [2:0] sel = cv.eeprom_pin_select;
   wire [2:0] gp  = ~cv.led_select & cv.pin_direction;
   wire [2:0] pp  = gp & cv.pin_buffer_type;
   wire [2:0] od  = gp & ~cv.pin_buffer_type;
   wire [2:0] inp = ~cv.led_select & ~cv.pin_direction;
   wire       rsv = (sel == 3'h2) || (sel == 3'h4);
   wire       d_x = (sel == 3'h1 || sel == 3'h3) ? cv.general_output_data[0] : (sel == 3'h7) ? tx_clk_in : tx_en_in;
   wire       c_x = (sel == 3'h0) ? ee_clock_in : (sel == 3'h1 || sel == 3'h5) ? cv.general_output_data[1] :
                    (sel == 3'h7) ? rx_clk_in : rx_dv_in;

   default clocking @(posedge core_clk_in); endclocking
   default disable iff (!nrst_in);

   AST_LED_DRIVE: assert property (
      (gpio_oe_n_out & $past(cv.led_select)) == 3'h0 &&
      ((gpio_out ^ $past(led_link_in)) & $past(cv.led_select)) == 3'h0) else $error("led pin not driven");
   AST_DIR_INPUT: assert property (
      (~gpio_oe_n_out & $past(inp)) == 3'h0) else $error("input pin driven");
   AST_PUSH_PULL: assert property (
      (gpio_oe_n_out & $past(pp)) == 3'h0 &&
      ((gpio_out ^ $past(cv.pin_data)) & $past(pp)) == 3'h0) else $error("push-pull drive wrong");
   AST_OPEN_DRAIN: assert property (
      ((gpio_oe_n_out ^ $past(cv.pin_data)) & $past(od)) == 3'h0 &&
      (~gpio_oe_n_out & gpio_out & $past(od)) == 3'h0) else $error("open-drain drive wrong");
   AST_EE_CLOCK: assert property (
      $past(nrst_in) && !$past(rsv) |-> eeprom_clock_pin_out == $past(c_x)) else $error("clock pin route wrong");
   AST_EE_DATA: assert property (
      $past(nrst_in) && $past(sel) != 3'h0 && !$past(rsv) |->
      !eeprom_data_pin_oe_n_out && eeprom_data_pin_out == $past(d_x)) else $error("data pin route wrong");
   AST_READBACK: assert property (
      avs_read_in && !avs_waitrequest_out && avs_address_in[7:2] == GPC_CFG_OFFSET[7:2] |->
      avs_readdata_out[31:3] == cfg_q[31:3]) else $error("config readback wrong");
   AST_IRQ_MASKED: assert property (
      mask_q == 3'h0 |-> !irq_out) else $error("masked interrupt raised");

   COV_IRQ: cover property (irq_out);
   COV_LED: cover property (cv.led_select == 3'h7);
   COV_CLKS: cover property (sel == 3'h7);
endmodule

bind gpc_pin_config gpc_pin_config_chk chk_u (.*);

// >>> test/gpc_board_model.sv
// Board model: pull-ups on the shared pins and the EEPROM data line
module gpc_board_model
   import gpc_pkg::*;
(
   input  wire logic [2:0] gpio_out_in,  // Block drive
   input  wire logic [2:0] gpio_oe_n_in, // Block enable, low
   input  wire logic [2:0] ext_en_in,    // Outside driver on
   input  wire logic [2:0] ext_val_in,   // Outside level
   output logic      [2:0] gpio_lvl_out, // Wire level
   input  wire logic       ee_out_in,    // Data pin drive
   input  wire logic       ee_oe_n_in,   // Data enable, low
   output logic            ee_lvl_out    // Data wire level
);
   timeunit 1ns;
   timeprecision 1ps;
   // Outside driver wins; a released line floats up to its pull-up
   assign gpio_lvl_out = (ext_en_in & ext_val_in) |
                         (~ext_en_in & ((~gpio_oe_n_in & gpio_out_in) | gpio_oe_n_in));
   // No EEPROM fitted, so a released data line rests high
   assign ee_lvl_out = ee_oe_n_in | ee_out_in;
endmodule

// >>> test/gpc_pin_config_tb_top.sv
// Self-checking bench for the pin function configuration block
module gpc_pin_config_tb_top
   import gpc_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   logic        core_clk_in = 1'b0;
   logic        nrst_in = 1'b0;
   logic [7:0]  avs_address_in = 8'h00;
   logic        avs_read_in = 1'b0, avs_write_in = 1'b0, avs_waitrequest_out, irq_out;
   logic [31:0] avs_writedata_in = 32'h0, avs_readdata_out;
   logic [2:0]  gpio_in, gpio_out, gpio_oe_n_out, led_link_in = 3'h5, ext_en = 3'h0, ext_val = 3'h0;
   logic        ee_data_out_in = 1'b1, ee_data_oe_in = 1'b1, ee_clock_in = 1'b1, ee_data_in_out;
   logic        tx_en_in = 1'b1, rx_dv_in = 1'b0, tx_clk_in = 1'b0, rx_clk_in = 1'b1;
   logic        eeprom_data_pin_in, eeprom_data_pin_out, eeprom_data_pin_oe_n_out, eeprom_clock_pin_out;
   int          n_errors = 0, comparisons = 0;

   // 100 MHz system clock
   always #5 core_clk_in = ~core_clk_in;

   gpc_pin_config dut_u (.avs_byteenable_in(4'hF), .*);
   gpc_board_model brd_u (.gpio_out_in(gpio_out), .gpio_oe_n_in(gpio_oe_n_out), .ext_en_in(ext_en),
      .ext_val_in(ext_val), .gpio_lvl_out(gpio_in), .ee_out_in(eeprom_data_pin_out),
      .ee_oe_n_in(eeprom_data_pin_oe_n_out), .ee_lvl_out(eeprom_data_pin_in));

   task automatic complete_run;
      if (n_errors == 0 && comparisons > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic cmp(input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e) begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   // One bus access; waitrequest is read at each rising edge, as the slave sees it there
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      int n;
      bit ok;
      n = 0;
      ok = 0;
      @(posedge core_clk_in);
      avs_address_in <= a;
      avs_writedata_in <= d;
      avs_write_in <= wr;
      avs_read_in <= ~wr;
      while (!ok && n < 50) begin
         @(posedge core_clk_in);
         ok = (avs_waitrequest_out === 1'b0);
         n++;
      end
      q = avs_readdata_out;
      avs_write_in <= 1'b0;
      avs_read_in <= 1'b0;
      if (!ok) begin
         n_errors++;
         complete_run();
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      cmp(q, e);
   endtask

   // Pin outputs are registered, so let the edge after the write land
   task automatic settle;
      repeat (2) @(negedge core_clk_in);
   endtask

   task automatic pins(input logic [2:0] oe, input logic [2:0] o);
      settle();
      cmp({29'h0, gpio_oe_n_out}, {29'h0, oe});
      cmp({29'h0, gpio_out & ~gpio_oe_n_out}, {29'h0, o & ~oe});
   endtask

   // Reset values, reserved bits, unmapped place, all pins as LEDs
   task automatic t_regs;
      rd(GPC_CFG_OFFSET, 32'h7);
      rd(GPC_STS_OFFSET, 32'h0);
      rd(GPC_MASK_OFFSET, 32'h0);
      wr(8'h40, 32'hFFFF_FFFF);
      rd(8'h40, 32'h0);
      wr(GPC_CFG_OFFSET, 32'hFFFF_FFFF);
      pins(3'h0, led_link_in);
      rd(GPC_CFG_OFFSET, (GPC_CFG_WR_MASK & ~32'h7) | {29'h0, led_link_in});
      wr(GPC_CFG_OFFSET, 32'h0);
   endtask

   // Push-pull, open-drain, input and LED pins side by side
   task automatic t_pins;
      wr(GPC_CFG_OFFSET, 32'h4001_0702);
      pins(3'h2, 3'h4);
      rd(GPC_CFG_OFFSET, 32'h4001_0706);
      wr(GPC_CFG_OFFSET, 32'h0002_0305);
      pins(3'h5, 3'h0);
      @(posedge core_clk_in);
      ext_en <= 3'h4;
      rd(GPC_CFG_OFFSET, 32'h0002_0301);
      ext_en <= 3'h0;
      wr(GPC_CFG_OFFSET, 32'h0000_0100);
      pins(3'h6, 3'h0);
   endtask

   function automatic logic [31:0] ee_exp(input int s);
      logic d;
      logic c;
      d = 1'b0;
      c = 1'b1;
      case (s)
         3: c = rx_dv_in;
         5: d = tx_en_in;
         6: begin
            d = tx_en_in;
            c = rx_dv_in;
         end
         7: begin
            d = tx_clk_in;
            c = rx_clk_in;
         end
         default: ;
      endcase
      if (s == 0)
         return {29'h0, ~ee_data_oe_in, ee_data_out_in, ee_clock_in};
      return {29'h0, 1'b0, d, c};
   endfunction

   // Every routing code in turn, reserved ones left alone
   task automatic t_ee;
      int codes[6] = '{1, 3, 5, 6, 7, 0};
      logic [31:0] e;
      foreach (codes[i]) begin
         wr(GPC_CFG_OFFSET, (32'(codes[i]) << GPC_EE_SEL_LSB) | 32'h10);
         settle();
         e = ee_exp(codes[i]);
         cmp({29'h0, eeprom_data_pin_oe_n_out, eeprom_data_pin_out, eeprom_clock_pin_out}, e);
         cmp({31'h0, ee_data_in_out}, {31'h0, e[2] | e[1]});
      end
      rd(GPC_CFG_OFFSET, 32'h17);
   endtask

   // Level interrupts: polarity, mask, too short a level, clear
   task automatic t_irq;
      // Earlier pin scenarios leave low levels latched; start clean
      wr(GPC_STS_OFFSET, 32'h7);
      wr(GPC_CFG_OFFSET, 32'h0100_0000);
      repeat (8) @(posedge core_clk_in);
      rd(GPC_STS_OFFSET, 32'h1);
      cmp({31'h0, irq_out}, 32'h0);
      wr(GPC_MASK_OFFSET, 32'h1);
      settle();
      cmp({31'h0, irq_out}, 32'h1);
      wr(GPC_CFG_OFFSET, 32'h0);
      wr(GPC_STS_OFFSET, 32'h7);
      rd(GPC_STS_OFFSET, 32'h0);
      wr(GPC_MASK_OFFSET, 32'h7);
      @(posedge core_clk_in);
      ext_en <= 3'h4;
      repeat (3) @(posedge core_clk_in);
      ext_en <= 3'h0;
      rd(GPC_STS_OFFSET, 32'h0);
      ext_en <= 3'h4;
      repeat (5) @(posedge core_clk_in);
      ext_en <= 3'h0;
      rd(GPC_STS_OFFSET, 32'h4);
      cmp({31'h0, irq_out}, 32'h1);
      wr(GPC_STS_OFFSET, 32'h4);
      rd(GPC_STS_OFFSET, 32'h0);
      cmp({31'h0, irq_out}, 32'h0);
   endtask

   // Main sequence
   initial begin
      repeat (16) @(posedge core_clk_in);
      nrst_in <= 1'b1;
      t_regs();
      t_pins();
      t_ee();
      t_irq();
      complete_run();
   end
endmodule
